// ### include/nvmac_pkg.sv
// Package for the nonvolatile data access controller
package nvmac_pkg;
	localparam int NVMAC_ADDR_W       = 7;
	localparam int NVMAC_DATA_W       = 8;
	localparam int NVMAC_CTRL_W       = 4;
	localparam int NVMAC_READ_GO_BIT  = 0;
	localparam int NVMAC_READ_PRM_BIT = 1;
	localparam int NVMAC_STORE_GO_BIT = 2;
	localparam int NVMAC_STORE_PRM_BIT = 3;
	localparam logic [7:0] NVMAC_CTRL_LOW_ADDR = 8'h40;
	localparam logic [7:0] NVMAC_CTRL_SECTOR   = 8'h01;
	localparam logic [7:0] NVMAC_PTR_HI_RST    = 8'h00;
	localparam logic [7:0] NVMAC_DATA_RST      = 8'h00;
	localparam logic [3:0] NVMAC_CTRL_RST      = 4'h0;
	localparam int NVMAC_READ_CYCLES  = 2;
	localparam int NVMAC_WTICKS       = 4;
	localparam int NVMAC_DEPTH        = 128;
	typedef enum logic [2:0] {
		NVMAC_IDLE  = 3'b001,
		NVMAC_READ  = 3'b010,
		NVMAC_WRITE = 3'b100
	} nvmac_state_t;
endpackage

// ### rtl/nvmac_tick_sync.sv
// Synchroniser and edge detector for the asynchronous write timer tick
`timescale 1ns/1ps
module nvmac_tick_sync (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic tick_async,
	output logic      tick_pulse
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= tick_async;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	// One pulse per rising edge of the timer
	assign tick_pulse = sync_q & ~last_q;
endmodule

// ### rtl/nvmac_ctrl.sv
// Nonvolatile data memory access controller with store and fetch cycles
`timescale 1ns/1ps
// Summary of operation
// [R1] Read go starts a fetch only when read permit is already set.
// [R2] Fetch end clears read go and loads the fetched byte to data.
// [R3] Data register holds its byte until the next read or write.
// [R4] Software sets permit and address first, then polls read go.
// [R5] Software loads address and data before starting a store.
// [R6] Software sets store permit then store go in the next cycle.
// [R7] Store go without store permit already set is ignored.
// [R8] Store duration counts ticks of an asynchronous internal timer.
// [R9] Store end clears store go so software can poll completion.
// [R10] Software clears global enable around launching a store.
// [R11] Store permit is cleared at reset.
// [R12] Pointer high byte resets to zero, selecting sector zero.
// [R13] Store end sets the write-complete request flag.
// [R14] Vector taken when flag, mask, global enable set, stack not full.
// [R15] Servicing clears the request flag and the global enable.
// [R16] Software must not sleep before an access has completed.
// [R17] Software rewrites the address before every read.
// [R18] Control register reached at pointer low 40h, high 01h.
// [R19] Read permit is bit 1, read go is bit 0.
// [R20] Store permit is bit 3, store go is bit 2.
// [R21] Software never sets both go bits or all four bits together; t_read_in_store writes 0Fh during a store.
// [R22] Software ensures the low speed clock is stable before a store.
// [R23] Read go during a store is ignored; data is left unchanged.
module nvmac_ctrl
	import nvmac_pkg::*;
#(
	parameter int ADDR_W = NVMAC_ADDR_W,
	parameter int DEPTH  = NVMAC_DEPTH,
	parameter int WTICKS = NVMAC_WTICKS
) (
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	input  wire logic              addr_we,
	input  wire logic [7:0]        addr_wdata,
	input  wire logic              data_we,
	input  wire logic [7:0]        data_wdata,
	input  wire logic              ptr_low_we,
	input  wire logic              ptr_high_we,
	input  wire logic [7:0]        ptr_wdata,
	input  wire logic              indirect_we,
	input  wire logic [7:0]        indirect_wdata,
	input  wire logic              irq_mask_we,
	input  wire logic              irq_mask_wdata,
	input  wire logic              global_en_we,
	input  wire logic              global_en_wdata,
	input  wire logic              stack_full,
	input  wire logic              irq_ack,
	input  wire logic              low_speed_clock,
	output logic [7:0]             nvm_addr_reg,
	output logic [7:0]             nvm_data_reg,
	output logic [7:0]             indirect_port,
	output logic [7:0]             ptr_low_byte,
	output logic [7:0]             ptr_high_byte,
	output logic                   nvm_irq_mask,
	output logic                   nvm_irq_flag,
	output logic                   global_irq_en,
	output logic                   irq_req,
	output logic                   busy
);
	//////////////////////////////////////////////////////////////////////
	logic [ADDR_W-1:0]       addr_q;
	logic [7:0]              data_q;
	logic [NVMAC_CTRL_W-1:0] ctrl_q;
	logic [7:0]              ptr_lo_q;
	logic [7:0]              ptr_hi_q;
	logic                    mask_q;
	logic                    flag_q;
	logic                    gie_q;
	logic [7:0]              mem_q [DEPTH];
	nvmac_state_t            state_q;
	nvmac_state_t            state_d;
	logic [3:0]              cnt_q;
	logic                    tick;
	logic                    ctrl_sel;
	logic                    ctrl_we;
	logic                    read_start;
	logic                    store_start;
	logic                    read_done;
	logic                    store_done;

	nvmac_tick_sync u_tick (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.tick_async (low_speed_clock),
		.tick_pulse (tick)
	);

	//////////////////////////////////////////////////////////////////////
	// Control register is visible only through the sector 1 window
	assign ctrl_sel = (ptr_lo_q == NVMAC_CTRL_LOW_ADDR) &&
		(ptr_hi_q == NVMAC_CTRL_SECTOR); // [R18]
	assign ctrl_we = indirect_we & ctrl_sel;

	// Permit must already be stored before the go write arrives
	assign read_start = ctrl_we && state_q == NVMAC_IDLE &&
		indirect_wdata[NVMAC_READ_GO_BIT] &&
		ctrl_q[NVMAC_READ_PRM_BIT]; // [R1] [R19] [R23]
	assign store_start = ctrl_we && state_q == NVMAC_IDLE &&
		indirect_wdata[NVMAC_STORE_GO_BIT] &&
		ctrl_q[NVMAC_STORE_PRM_BIT]; // [R7] [R20]

	assign read_done = state_q == NVMAC_READ &&
		cnt_q == 4'(NVMAC_READ_CYCLES - 1);
	assign store_done = state_q == NVMAC_WRITE && tick &&
		cnt_q == 4'(WTICKS - 1); // [R8]

	//////////////////////////////////////////////////////////////////////
	always_comb begin
		state_d = state_q;
		case (state_q)
			NVMAC_IDLE: begin
				if (store_start)
					state_d = NVMAC_WRITE;
				else if (read_start)
					state_d = NVMAC_READ;
			end
			NVMAC_READ: begin
				if (read_done)
					state_d = NVMAC_IDLE;
			end
			NVMAC_WRITE: begin
				if (store_done)
					state_d = NVMAC_IDLE;
			end
			default: state_d = NVMAC_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			state_q <= NVMAC_IDLE;
		else
			state_q <= state_d;
	end

	// Read counts system cycles, store counts timer ticks
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			cnt_q <= 4'h0;
		else if (state_q != state_d)
			cnt_q <= 4'h0;
		else if (state_q == NVMAC_READ)
			cnt_q <= cnt_q + 4'h1;
		else if (state_q == NVMAC_WRITE && tick)
			cnt_q <= cnt_q + 4'h1; // [R8]
	end

	//////////////////////////////////////////////////////////////////////
	// Control bits; go bits are cleared by hardware at cycle end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_q <= NVMAC_CTRL_RST; // [R11]
		end else begin
			if (ctrl_we) begin
				ctrl_q[NVMAC_READ_PRM_BIT] <=
					indirect_wdata[NVMAC_READ_PRM_BIT];
				ctrl_q[NVMAC_STORE_PRM_BIT] <=
					indirect_wdata[NVMAC_STORE_PRM_BIT];
				// Clearing go aborts nothing; it only drops when idle
				if (state_q == NVMAC_IDLE) begin
					ctrl_q[NVMAC_READ_GO_BIT] <= read_start; // [R1]
					ctrl_q[NVMAC_STORE_GO_BIT] <= store_start; // [R7]
				end
			end
			if (read_done)
				ctrl_q[NVMAC_READ_GO_BIT] <= 1'b0; // [R2]
			if (store_done)
				ctrl_q[NVMAC_STORE_GO_BIT] <= 1'b0; // [R9]
		end
	end

	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			addr_q <= '0;
		else if (addr_we && state_q == NVMAC_IDLE)
			addr_q <= addr_wdata[ADDR_W-1:0];
	end

	// Data changes only on a software write or a finished fetch
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			data_q <= NVMAC_DATA_RST;
		else if (read_done)
			data_q <= mem_q[addr_q]; // [R2]
		else if (data_we && state_q == NVMAC_IDLE)
			data_q <= data_wdata; // [R3]
	end

	// Array content is nonvolatile and is not reset
	always_ff @(posedge sys_clk) begin
		if (store_done)
			mem_q[addr_q] <= data_q; // [R9]
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ptr_lo_q <= 8'h00;
			ptr_hi_q <= NVMAC_PTR_HI_RST; // [R12]
		end else begin
			if (ptr_low_we)
				ptr_lo_q <= ptr_wdata;
			if (ptr_high_we)
				ptr_hi_q <= ptr_wdata;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Interrupt request flag: a new store end wins over the service clear
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			flag_q <= 1'b0;
		else if (store_done)
			flag_q <= 1'b1; // [R13]
		else if (irq_ack)
			flag_q <= 1'b0; // [R15]
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			mask_q <= 1'b0;
		else if (irq_mask_we)
			mask_q <= irq_mask_wdata;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			gie_q <= 1'b0;
		else if (irq_ack)
			gie_q <= 1'b0; // [R15]
		else if (global_en_we)
			gie_q <= global_en_wdata;
	end

	assign irq_req = flag_q & mask_q & gie_q & ~stack_full; // [R14]

	//////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			busy <= 1'b0;
		else
			busy <= state_d != NVMAC_IDLE;
	end

	assign nvm_addr_reg  = 8'(addr_q);
	assign nvm_data_reg  = data_q;
	assign indirect_port = ctrl_sel ? {4'h0, ctrl_q} : 8'h00;
	assign ptr_low_byte  = ptr_lo_q;
	assign ptr_high_byte = ptr_hi_q;
	assign nvm_irq_mask  = mask_q;
	assign nvm_irq_flag  = flag_q;
	assign global_irq_en = gie_q;
endmodule

// ### verif/nvmac_checker.sv
// Assertion checker for the nonvolatile access controller
`timescale 1ns/1ps
module nvmac_checker (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire logic       indirect_we,
	input wire logic [7:0] indirect_wdata,
	input wire logic       irq_ack,
	input wire logic       global_en_we,
	input wire logic       data_we,
	input wire logic       stack_full,
	input wire logic [7:0] nvm_data_reg,
	input wire logic [7:0] indirect_port,
	input wire logic [7:0] ptr_low_byte,
	input wire logic [7:0] ptr_high_byte,
	input wire logic       nvm_irq_mask,
	input wire logic       nvm_irq_flag,
	input wire logic       global_irq_en,
	input wire logic       irq_req,
	input wire logic       busy
);
	logic [3:0] c;
	logic       sel;
	assign c = indirect_port[3:0];
	assign sel = ptr_low_byte == 8'h40 && ptr_high_byte == 8'h01;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_store_end;
		sel && c[2] && busy ##1 sel && !c[2];
	endsequence
	AST_RD_NOPERM: assert property (indirect_we && sel && indirect_wdata[0]
		&& !c[1] && !busy |=> !busy) else $error("read started unpermitted");
	AST_RD_DONE: assert property ($rose(busy) && c[0] |-> ##[1:3] !c[0])
		else $error("read go not cleared");
	AST_DATA_HOLD: assert property (!busy && !$past(busy) && !data_we
		|=> $stable(nvm_data_reg)) else $error("data changed idle");
	AST_WR_NOPERM: assert property (indirect_we && sel && indirect_wdata[2]
		&& !c[3] && !busy |=> !busy) else $error("store unpermitted");
	AST_WR_TIME: assert property ($rose(busy) && c[2] |=> c[2])
		else $error("store ended at once");
	AST_STORE_FLAG: assert property (s_store_end |-> nvm_irq_flag)
		else $error("flag not set at store end");
	AST_RST_CLEAR: assert property (@(posedge sys_clk) disable iff (1'b0)
		sys_rst |=>
		ptr_high_byte == 8'h00 && indirect_port == 8'h00)
		else $error("reset values wrong");
	AST_IRQ_REQ: assert property (irq_req == (nvm_irq_flag && nvm_irq_mask
		&& global_irq_en && !stack_full)) else $error("irq_req wrong");
	AST_ACK_CLEAR: assert property (irq_ack && !busy && !global_en_we
		|=> !nvm_irq_flag && !global_irq_en) else $error("ack no clear");
	AST_RD_IN_STORE: assert property (busy && c[2] && indirect_we && sel
		|=> !c[0]) else $error("read taken during store");
endmodule
bind nvmac_ctrl nvmac_checker u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.indirect_we(indirect_we), .indirect_wdata(indirect_wdata),
	.irq_ack(irq_ack), .global_en_we(global_en_we), .data_we(data_we),
	.stack_full(stack_full), .nvm_data_reg(nvm_data_reg),
	.indirect_port(indirect_port), .ptr_low_byte(ptr_low_byte),
	.ptr_high_byte(ptr_high_byte), .nvm_irq_mask(nvm_irq_mask),
	.nvm_irq_flag(nvm_irq_flag), .global_irq_en(global_irq_en),
	.irq_req(irq_req), .busy(busy));

// ### verif/test_eeprom_data_access_ctrl.sv
// Self-checking testbench for the nonvolatile access controller
`timescale 1ns/1ps
module test_eeprom_data_access_ctrl;
	logic       sys_clk = 0, sys_rst = 1, low_speed_clock = 0;
	logic       addr_we, data_we, ptr_low_we, ptr_high_we, indirect_we;
	logic       irq_mask_we, irq_mask_wdata, global_en_we, global_en_wdata;
	logic       stack_full, irq_ack, nvm_irq_mask, nvm_irq_flag;
	logic       global_irq_en, irq_req, busy;
	logic [7:0] addr_wdata, data_wdata, ptr_wdata, indirect_wdata;
	logic [7:0] nvm_addr_reg, nvm_data_reg, indirect_port;
	logic [7:0] ptr_low_byte, ptr_high_byte;
	int         n_mismatch = 0, samples_checked = 0, cyc = 0;
	nvmac_ctrl #(.WTICKS(2)) dut (.*);
	always #5 sys_clk = ~sys_clk;
	always #37 low_speed_clock = ~low_speed_clock;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_mismatch++;
			tally_and_finish;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] k, input logic [7:0] v);
		@(posedge sys_clk);
		{addr_we, data_we, ptr_low_we, ptr_high_we} <= k;
		addr_wdata <= v;
		data_wdata <= v;
		ptr_wdata <= v;
		@(posedge sys_clk);
		{addr_we, data_we, ptr_low_we, ptr_high_we} <= 4'h0;
	endtask
	task ind(input logic [7:0] a, input logic [7:0] b);
		@(posedge sys_clk);
		indirect_we <= 1;
		indirect_wdata <= a;
		@(posedge sys_clk);
		indirect_wdata <= b;
		@(posedge sys_clk);
		indirect_we <= 0;
		#1;
	endtask
	task wait_go(input int b);
		for (int i = 0; i < 400 && indirect_port[b] === 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
		end
		chk({7'h0, indirect_port[b]}, 8'h00);
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_refused;
		chk(ptr_high_byte, 8'h00);
		wr(4'h2, 8'h40);
		wr(4'h1, 8'h01);
		#1 chk(indirect_port, 8'h00);
		chk(ptr_low_byte, 8'h40);
		ind(8'h04, 8'h04);
		chk({7'h0, busy}, 8'h00);
		ind(8'h01, 8'h01);
		chk(indirect_port, 8'h00);
		$display("refused go done");
	endtask
	task t_store_read(input logic [7:0] d);
		wr(4'h8, 8'h05);
		#1 chk(nvm_addr_reg, 8'h05);
		wr(4'h4, d);
		ind(8'h08, 8'h0c);
		chk(indirect_port, 8'h0c);
		wait_go(2);
		chk({7'h0, nvm_irq_flag}, 8'h01);
		wr(4'h4, 8'h00);
		wr(4'h8, 8'h05);
		ind(8'h02, 8'h03);
		wait_go(0);
		chk(nvm_data_reg, d);
		chk(indirect_port, 8'h02);
		repeat (5) @(posedge sys_clk);
		#1 chk(nvm_data_reg, d);
		$display("store and read done");
	endtask
	task t_read_in_store;
		wr(4'h4, 8'h3c);
		ind(8'h08, 8'h0c);
		ind(8'h0e, 8'h0f);
		wait_go(2);
		chk(indirect_port, 8'h0a);
		chk(nvm_data_reg, 8'h3c);
		$display("read during store done");
	endtask
	task t_irq;
		@(posedge sys_clk);
		{irq_mask_we, irq_mask_wdata, global_en_we, global_en_wdata} <= 4'hf;
		@(posedge sys_clk);
		{irq_mask_we, global_en_we} <= 2'b00;
		#1 chk({7'h0, irq_req}, 8'h01);
		chk({7'h0, nvm_irq_mask}, 8'h01);
		@(posedge sys_clk);
		stack_full <= 1;
		#1 chk({7'h0, irq_req}, 8'h00);
		@(posedge sys_clk);
		stack_full <= 0;
		irq_ack <= 1;
		@(posedge sys_clk);
		irq_ack <= 0;
		#1 chk({6'h0, nvm_irq_flag, global_irq_en}, 8'h00);
		$display("interrupt done");
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{addr_we, data_we, ptr_low_we, ptr_high_we, indirect_we} = '0;
		{irq_mask_we, irq_mask_wdata, global_en_we, global_en_wdata} = '0;
		{stack_full, irq_ack} = '0;
		{addr_wdata, data_wdata, ptr_wdata, indirect_wdata} = '0;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 0;
		t_refused;
		t_store_read(8'ha5);
		t_store_read(8'h5a);
		t_read_in_store;
		t_irq;
		tally_and_finish;
	end
endmodule
